// ===== logic/gdp_port.sv
// module: gpio data/direction port top with register port, pin drivers and edge interrupt
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module gdp_port (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic sys_gpio_irq_en,
    output logic pin_edge_irq,
    output logic irq,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n
);
    typedef struct packed {
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic prev24;
        logic [15:0] stat;
        logic [15:0] mask;
        logic [15:0] rdata;
        logic [31:0] pout;
        logic [31:0] poe_n;
        logic edge_irq;
        logic irq;
    } gdp_state_t;

    logic [1:0] rst_sync;
    logic rst_n;
    gdp_state_t s;
    gdp_state_t next_s;
    gdp_regs_if rif ();

    // spreads a bank 1 register onto pins 31:29, 24, 23:19
    function automatic logic [31:0] gdp_pins(input logic [15:0] b0, input logic [15:0] b1);
        logic [31:0] p;
        p = {b0, b0};
        p[31:29] = b1[15:13];
        p[28:25] = 4'h0;
        p[24] = b1[8];
        p[23:19] = b1[7:3];
        p[18:16] = 3'h0;
        return p;
    endfunction

    // gathers pins 31:16 back into bank 1 layout
    function automatic logic [15:0] gdp_bank1(input logic [31:0] p);
        return {p[31:29], 4'h0, p[24], p[23:19], 3'h0};
    endfunction

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rst_sync <= gdp_pkg::SYNC_RESET;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    assign rif.we = reg_wr;
    assign rif.addr = reg_addr;
    assign rif.wdata = reg_wdata;

    gdp_reg_store u_store (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rif(rif)
    );

    logic edge_seen;
    logic irq_gate;
    logic [31:0] drv;
    logic [31:0] oe;

    always_comb
    begin
        next_s = s;
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;
        next_s.prev24 = s.sync2[gdp_pkg::IRQ_PIN];
        // edge on the synchronised pin 24, polarity from control bit 1
        if (rif.ctrl[gdp_pkg::CTRL_POL])
            edge_seen = s.sync2[gdp_pkg::IRQ_PIN] & ~s.prev24;
        else
            edge_seen = ~s.sync2[gdp_pkg::IRQ_PIN] & s.prev24;
        irq_gate = rif.ctrl[gdp_pkg::CTRL_IRQ_EN] & sys_gpio_irq_en;
        next_s.edge_irq = edge_seen & irq_gate;
        // set wins over write-one-to-clear
        if (reg_wr && reg_addr == gdp_pkg::OFF_IRQ_STAT)
            next_s.stat = s.stat & ~reg_wdata;
        if (reg_wr && reg_addr == gdp_pkg::OFF_IRQ_MASK)
            next_s.mask = reg_wdata & gdp_pkg::STAT_MASK;
        if (edge_seen & irq_gate)
            next_s.stat[gdp_pkg::STAT_EDGE] = 1'b1;
        next_s.irq = |(next_s.stat & s.mask);
        drv = gdp_pins(rif.out0, rif.out1);
        oe = gdp_pins(rif.dir0, rif.dir1);
        next_s.pout = drv;
        next_s.poe_n = ~oe;
        next_s.rdata = gdp_pkg::ZERO16;
        if (reg_rd)
        begin
            case (reg_addr)
                gdp_pkg::OFF_CTRL: next_s.rdata = rif.ctrl;
                gdp_pkg::OFF_OUT0: next_s.rdata = rif.out0;
                gdp_pkg::OFF_OUT1: next_s.rdata = rif.out1;
                gdp_pkg::OFF_IN0: next_s.rdata = s.sync2[15:0];
                gdp_pkg::OFF_IN1: next_s.rdata = gdp_bank1(s.sync2);
                gdp_pkg::OFF_DIR0: next_s.rdata = rif.dir0;
                gdp_pkg::OFF_DIR1: next_s.rdata = rif.dir1;
                gdp_pkg::OFF_IRQ_STAT: next_s.rdata = s.stat;
                gdp_pkg::OFF_IRQ_MASK: next_s.rdata = s.mask;
                default: next_s.rdata = gdp_pkg::ZERO16;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.poe_n <= '1;
        end
        else
            s <= next_s;
    end

    assign reg_rdata = s.rdata;
    assign pin_edge_irq = s.edge_irq;
    assign irq = s.irq;
    assign pin_out = s.pout;
    assign pin_oe_n = s.poe_n;

    sequence gdp_rise_seq;
        !s.sync2[gdp_pkg::IRQ_PIN] ##1 s.sync2[gdp_pkg::IRQ_PIN];
    endsequence

    sequence gdp_fall_seq;
        s.sync2[gdp_pkg::IRQ_PIN] ##1 !s.sync2[gdp_pkg::IRQ_PIN];
    endsequence

    a_irq_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !$past(rif.ctrl[gdp_pkg::CTRL_IRQ_EN]) |-> !pin_edge_irq)
        else $error("edge irq passed while control enable clear");
    a_sys_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !$past(sys_gpio_irq_en) |-> !pin_edge_irq)
        else $error("edge irq passed while system enable clear");
    a_rise_detect: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (gdp_rise_seq ##0 (rif.ctrl[1] && rif.ctrl[0] && sys_gpio_irq_en))
        |=> pin_edge_irq)
        else $error("rising edge missed");
    a_fall_detect: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (gdp_fall_seq ##0 (!rif.ctrl[1] && rif.ctrl[0] && sys_gpio_irq_en))
        |=> pin_edge_irq)
        else $error("falling edge missed");
    a_out_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == gdp_pkg::OFF_OUT0) |=> reg_rdata == $past(rif.out0))
        else $error("output register readback wrong");
    a_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 pin_out[15:0] == $past(rif.out0))
        else $error("pin level differs from output bit");
    a_dir_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 pin_oe_n[24] == !$past(rif.dir1[8]))
        else $error("pin 24 driver enable wrong");
    a_input_path: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == gdp_pkg::OFF_IN0) |=> reg_rdata == $past(pin_in[15:0], 3))
        else $error("input register does not show synchronised pins");
    a_in1_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == gdp_pkg::OFF_IN1) |=> (reg_rdata & ~gdp_pkg::BANK1_MASK) == 16'h0000)
        else $error("reserved input bits not zero");
endmodule

// ===== logic/gdp_pkg.sv
// package: register map, field layout and reset values of the gpio data/direction port
package gdp_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PINS = 32;
    localparam logic [15:0] OFF_CTRL = 16'hc006;
    localparam logic [15:0] OFF_OUT0 = 16'hc01e;
    localparam logic [15:0] OFF_IN0 = 16'hc020;
    localparam logic [15:0] OFF_DIR0 = 16'hc022;
    localparam logic [15:0] OFF_OUT1 = 16'hc024;
    localparam logic [15:0] OFF_IN1 = 16'hc026;
    localparam logic [15:0] OFF_DIR1 = 16'hc028;
    localparam logic [15:0] OFF_IRQ_STAT = 16'hc02a;
    localparam logic [15:0] OFF_IRQ_MASK = 16'hc02c;
    // bank 1 implemented bits: 15:13, 8, 7:3
    localparam logic [15:0] BANK1_MASK = 16'he1f8;
    localparam logic [15:0] CTRL_MASK = 16'h0003;
    localparam int CTRL_IRQ_EN = 0;
    localparam int CTRL_POL = 1;
    localparam int IRQ_PIN = 24;
    localparam int STAT_EDGE = 0;
    localparam logic [15:0] STAT_MASK = 16'h0001;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// ===== logic/gdp_regs_if.sv
// interface: register write port between the top and the register store
`timescale 1ns/10ps
interface gdp_regs_if;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] out0;
    logic [15:0] out1;
    logic [15:0] dir0;
    logic [15:0] dir1;
    logic [15:0] ctrl;
    modport store (input we, input addr, input wdata, output out0, output out1,
        output dir0, output dir1, output ctrl);
    modport user (output we, output addr, output wdata, input out0, input out1,
        input dir0, input dir1, input ctrl);
endinterface

// ===== logic/gdp_reg_store.sv
// module: software-written control, output data and direction registers
`timescale 1ns/10ps
module gdp_reg_store (
    input wire logic clk_sys,
    input wire logic rst_n,
    gdp_regs_if.store rif
);
    typedef struct packed {
        logic [15:0] out0;
        logic [15:0] out1;
        logic [15:0] dir0;
        logic [15:0] dir1;
        logic [15:0] ctrl;
    } gdp_store_t;

    gdp_store_t st;
    gdp_store_t next_st;

    always_comb
    begin
        next_st = st;
        if (rif.we)
        begin
            // reserved bits are never stored
            case (rif.addr)
                gdp_pkg::OFF_OUT0: next_st.out0 = rif.wdata;
                gdp_pkg::OFF_OUT1: next_st.out1 = rif.wdata & gdp_pkg::BANK1_MASK;
                gdp_pkg::OFF_DIR0: next_st.dir0 = rif.wdata;
                gdp_pkg::OFF_DIR1: next_st.dir1 = rif.wdata & gdp_pkg::BANK1_MASK;
                gdp_pkg::OFF_CTRL: next_st.ctrl = rif.wdata & gdp_pkg::CTRL_MASK;
                default: next_st = st;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rif.out0 = st.out0;
    assign rif.out1 = st.out1;
    assign rif.dir0 = st.dir0;
    assign rif.dir1 = st.dir1;
    assign rif.ctrl = st.ctrl;

    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((st.out1 | st.dir1) & ~gdp_pkg::BANK1_MASK) == gdp_pkg::ZERO16)
        else $error("reserved bank 1 bit stored");
endmodule

// ===== verif/gdp_board_model.sv
// board model: resolves every pin from the port driver and the board driver
`timescale 1ns/10ps
module gdp_board_model (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] board_val,
    output logic [31:0] pin_in
);
    // the port wins where its driver is on, the board holds every other pin
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & board_val);
endmodule

// ===== verif/tb.sv
// testbench: register access, pin drive and sense, and edge interrupt of the port
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sys_gpio_irq_en = 1'b0;
    logic [31:0] board_val = 32'h0;
    logic [15:0] reg_rdata;
    logic pin_edge_irq;
    logic irq;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe_n;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int pulses = 0;
    gdp_port u_gdp_port (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_gpio_irq_en(sys_gpio_irq_en), .pin_edge_irq(pin_edge_irq), .irq(irq),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    gdp_board_model u_gdp_board_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .board_val(board_val), .pin_in(pin_in));
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (pin_edge_irq === 1'b1)
            pulses++;
        if (cycles == 3000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(n, e, reg_rdata)
    endtask
    // moves pin 24 and counts the request pulses that follow
    task automatic edge24(input logic v, input int exp, input string n);
        int p0;
        p0 = pulses;
        @(posedge clk_sys);
        board_val[24] <= v;
        repeat (8) @(posedge clk_sys);
        `CHK(n, exp, pulses - p0)
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        logic [15:0] offs [10];
        offs = '{gdp_pkg::OFF_OUT0, gdp_pkg::OFF_IN0, gdp_pkg::OFF_DIR0, gdp_pkg::OFF_OUT1,
            gdp_pkg::OFF_IN1, gdp_pkg::OFF_DIR1, gdp_pkg::OFF_CTRL, gdp_pkg::OFF_IRQ_STAT,
            gdp_pkg::OFF_IRQ_MASK, 16'hc030};
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (offs[i])
            rd_chk("reset", offs[i], 16'h0000);
        `CHK("oe_reset", 32'hffffffff, pin_oe_n)
        wr(gdp_pkg::OFF_OUT0, 16'ha5c3);
        wr(gdp_pkg::OFF_DIR0, 16'hffff);
        wr(gdp_pkg::OFF_OUT1, 16'hffff);
        wr(gdp_pkg::OFF_DIR1, 16'h0100);
        repeat (4) @(posedge clk_sys);
        `CHK("out_lo", 16'ha5c3, pin_out[15:0])
        `CHK("out_hi", 16'he1f8, pin_out[31:16])
        `CHK("oe_lo", 16'h0000, pin_oe_n[15:0])
        `CHK("oe_hi", 16'hfeff, pin_oe_n[31:16])
        rd_chk("out1", gdp_pkg::OFF_OUT1, 16'he1f8);
        rd_chk("in0_drv", gdp_pkg::OFF_IN0, 16'ha5c3);
        rd_chk("in1_drv", gdp_pkg::OFF_IN1, 16'h0100);
        wr(gdp_pkg::OFF_DIR0, 16'h0000);
        board_val <= 32'hffff3c96;
        rd_chk("in0_sync", gdp_pkg::OFF_IN0, 16'ha5c3);
        repeat (4) @(posedge clk_sys);
        rd_chk("out0_keep", gdp_pkg::OFF_OUT0, 16'ha5c3);
        rd_chk("in0_ext", gdp_pkg::OFF_IN0, 16'h3c96);
        rd_chk("in1_ext", gdp_pkg::OFF_IN1, 16'he1f8);
        // software keeps reserved bits at zero from here on
        wr(gdp_pkg::OFF_DIR1, 16'h0000);
        board_val <= 32'h0;
        wr(gdp_pkg::OFF_IRQ_MASK, 16'h0001);
        sys_gpio_irq_en <= 1'b1;
        wr(gdp_pkg::OFF_CTRL, 16'h0003);
        edge24(1'b1, 1, "rise_on");
        `CHK("irq_set", 1'b1, irq)
        rd_chk("stat_set", gdp_pkg::OFF_IRQ_STAT, 16'h0001);
        wr(gdp_pkg::OFF_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge clk_sys);
        `CHK("irq_clr", 1'b0, irq)
        edge24(1'b0, 0, "fall_rise_mode");
        wr(gdp_pkg::OFF_CTRL, 16'h0001);
        edge24(1'b1, 0, "rise_fall_mode");
        edge24(1'b0, 1, "fall_on");
        wr(gdp_pkg::OFF_IRQ_STAT, 16'h0001);
        wr(gdp_pkg::OFF_CTRL, 16'h0000);
        edge24(1'b1, 0, "ctrl_off_r");
        edge24(1'b0, 0, "ctrl_off_f");
        wr(gdp_pkg::OFF_CTRL, 16'h0001);
        sys_gpio_irq_en <= 1'b0;
        edge24(1'b1, 0, "sys_off_r");
        edge24(1'b0, 0, "sys_off_f");
        sys_gpio_irq_en <= 1'b1;
        wr(gdp_pkg::OFF_IRQ_MASK, 16'h0000);
        edge24(1'b1, 0, "mask_r");
        edge24(1'b0, 1, "mask_f");
        `CHK("irq_masked", 1'b0, irq)
        rd_chk("stat_masked", gdp_pkg::OFF_IRQ_STAT, 16'h0001);
        complete_run();
    end
endmodule
